// File: bench/ctl_model.sv
/*
  Serial controller model: frames transfers with chip select, drives the
  serial clock and data, and records result and strobe at each rise.
  Assumes the 20 MHz bench clock; one serial period is 8 clk, 5 low, 3 high.
*/
`timescale 1ns/1ps
module ctl_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout_pin,
  input  wire logic strobe_pin
);
  // ==========================================================
  // History, newest rise in bit 0
  logic [31:0] rx_bits;
  logic [31:0] strb_bits;

  initial begin
    cs_n      = 1'b1;
    sclk      = 1'b0;
    din       = 1'b0;
    rx_bits   = '0;
    strb_bits = '0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // Deselect parks the link clock low; clock_bits may still run it outside frames
  task automatic select();
    @(posedge clk);
    cs_n <= 1'b0;
    din  <= ~din;
    wait_clk(3);
  endtask : select

  task automatic deselect();
    @(posedge clk);
    sclk <= 1'b0;
    wait_clk(4);
    cs_n <= 1'b1;
    din  <= ~din;  // Released line must not keep a stale level
    // Deselect lasts several clk so the next frame never narrows it
    wait_clk(3);
  endtask : deselect

  // Start bit first, data set while low and held over the rise
  // Fixed 8 clk period keeps the link clock inside its allowed range
  task automatic clock_bits(input logic [7:0] tx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sclk <= 1'b0;
      din  <= tx[7];
      tx = tx << 1;
      wait_clk(5);
      sclk      <= 1'b1;
      rx_bits   <= {rx_bits[30:0], dout_pin};
      strb_bits <= {strb_bits[30:0], strobe_pin};
      wait_clk(2);
    end
  endtask : clock_bits

  // No read clock before the strobe has risen
  task automatic wait_strobe(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(posedge clk);
      seen = (strobe_pin === 1'b1);
    end
  endtask : wait_strobe
endmodule : ctl_model

// File: bench/tb_top.sv
/*
  Self-checking bench of the serial conversion port: external, internal,
  power-down and shutdown sequences through the controller model.
  Assumes the front end holds sample_code steady during a conversion.
*/
`timescale 1ns/1ps
module tb_top;
  import conv_pkg::*;
  // ==========================================================
  // Signals
  logic              clk;
  logic              rst_n;
  logic              hard_powerdown_n;
  logic [DATA_W-1:0] sample_code;
  logic              cs_n;
  logic              sclk;
  logic              din;
  logic              dout;
  logic              dout_oe;
  logic              conversion_strobe;
  logic              conversion_strobe_oe;
  logic [2:0]        channel_select;
  logic              input_config_select;
  logic              polarity_select;
  logic              mode_bit_hi;
  logic              mode_bit_lo;
  logic              powered_down;
  logic              seen;
  int                mismatches;
  int                samples_checked;
  wire logic         dout_pin   = dout_oe ? dout : 1'bz;
  wire logic         strobe_pin = conversion_strobe_oe ? conversion_strobe : 1'bz;
  logic [DATA_W-1:0] int_codes [2] = '{14'h1367, 14'h3fff};

  initial clk = 1'b0;
  always #25 clk = ~clk;

  adc_serial_conversion_port adc_serial_conversion_port_i (
    .clk                  (clk),
    .rst_n                (rst_n),
    .cs_n                 (cs_n),
    .sclk                 (sclk),
    .din                  (din),
    .dout                 (dout),
    .dout_oe              (dout_oe),
    .conversion_strobe    (conversion_strobe),
    .conversion_strobe_oe (conversion_strobe_oe),
    .hard_powerdown_n     (hard_powerdown_n),
    .sample_code          (sample_code),
    .channel_select       (channel_select),
    .input_config_select  (input_config_select),
    .polarity_select      (polarity_select),
    .mode_bit_hi          (mode_bit_hi),
    .mode_bit_lo          (mode_bit_lo),
    .powered_down         (powered_down)
  );
  ctl_model ctl_model_i (
    .clk        (clk),
    .cs_n       (cs_n),
    .sclk       (sclk),
    .din        (din),
    .dout_pin   (dout_pin),
    .strobe_pin (strobe_pin)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    rst_n            <= 1'b0;
    hard_powerdown_n <= 1'b1;
    sample_code      <= 14'h2a5c;
    ctl_model_i.wait_clk(5);
    rst_n <= 1'b1;
    ctl_model_i.wait_clk(3);
    check(powered_down, 1'b1);
    check(dout_oe, 1'b0);
    check({mode_bit_hi, mode_bit_lo}, 2'h0);
    $display("Test reset done");
    // External clock: leading zeros, byte, then 18 counted falls
    ctl_model_i.select();
    ctl_model_i.clock_bits(8'h00, 3);
    ctl_model_i.clock_bits(8'hdb, 26);
    check(dout_oe, 1'b1);
    check(conversion_strobe_oe, 1'b1);
    check({channel_select, input_config_select, polarity_select, mode_bit_hi,
           mode_bit_lo}, 7'h5b);
    check(powered_down, 1'b0);
    check(ctl_model_i.strb_bits[17:0], 18'h30000);
    check(ctl_model_i.rx_bits[14:0], {14'h2a5c, 1'b0});
    ctl_model_i.deselect();
    ctl_model_i.wait_clk(6);
    check(dout_oe, 1'b0);
    check(conversion_strobe_oe, 1'b0);
    $display("Test external done");
    // Internal clock, twice so the strobe falls from high the second time
    for (int i = 0; i < 2; i++) begin
      sample_code <= int_codes[i];
      ctl_model_i.select();
      ctl_model_i.clock_bits(8'h8e, 8);
      ctl_model_i.wait_clk(4);
      check(conversion_strobe, 1'b0);
      ctl_model_i.wait_strobe(seen);
      check(seen, 1'b1);
      ctl_model_i.clock_bits(8'h00, 14);
      check(ctl_model_i.rx_bits[13:0], int_codes[i]);
      check({mode_bit_hi, mode_bit_lo}, 2'h2);
      ctl_model_i.deselect();
    end
    $display("Test internal done");
    // Shutdown overrides the strobe that internal mode keeps driven
    hard_powerdown_n <= 1'b0;
    ctl_model_i.wait_clk(6);
    check(powered_down, 1'b1);
    check(conversion_strobe_oe, 1'b0);
    hard_powerdown_n <= 1'b1;
    ctl_model_i.wait_clk(4);
    $display("Test shutdown done");
    for (int m = 0; m < 2; m++) begin
      ctl_model_i.select();
      ctl_model_i.clock_bits(8'ha4 | 8'(m), 8);
      ctl_model_i.deselect();
      ctl_model_i.wait_clk(6);
      check(powered_down, 1'b1);
      check({mode_bit_hi, mode_bit_lo}, 2'(m));
    end
    // Clocking with chip select high must change nothing
    ctl_model_i.clock_bits(8'hff, 8);
    ctl_model_i.wait_clk(6);
    check({mode_bit_hi, mode_bit_lo, powered_down}, 3'h3);
    $display("Test power-down done");
    complete_run();
  end
endmodule : tb_top

// File: rtl/adc_serial_conversion_port.sv
/*
  Serial control and conversion sequencing port of a 14-bit converter.
  Receives the control byte, runs conversions paced by the serial clock
  or an internal step timer, and shifts results out with a strobe.
  Assumes all pins are asynchronous to clk and much slower than it;
  the sampled held value arrives on sample_code in the clk domain.
*/
// Operation
// RQ1 - While selected, the result output changes on serial clock falling edges.
// RQ2 - The result output is released whenever chip select is high.
// RQ3 - Input bits are taken on serial clock rising edges only while selected.
// RQ4 - In internal clock mode the strobe goes low at conversion start, high at its end.
// RQ5 - In external clock mode the strobe is high for two serial periods before the MSB decision.
// RQ6 - In external clock mode the strobe is driven only while chip select is low.
// RQ7 - In external clock mode each conversion step is paced by a serial clock edge.
// RQ8 - The controller keeps the serial clock within its allowed frequency range.
// RQ9 - In internal clock mode the controller reads only after the strobe has risen.
// RQ10 - Holding the shutdown input low forces shutdown; high re-enables the port.
// RQ11 - The first one after selection starts the control byte; fields follow MSB first.
// RQ12 - Mode bits pick full power-down, fast power-down, internal or external clock.
// RQ13 - Each conversion takes fifteen conversion clock steps.
// RQ14 - In external clock mode a conversion completes at the eighteenth counted fall.
`timescale 1ns/1ps
module adc_serial_conversion_port
  import conv_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  output logic                   conversion_strobe,
  output logic                   conversion_strobe_oe,
  // Shutdown pin
  input  wire logic              hard_powerdown_n,
  // Held analog value from the front end
  input  wire logic [DATA_W-1:0] sample_code,
  // Status
  output logic [2:0]             channel_select,
  output logic                   input_config_select,
  output logic                   polarity_select,
  output logic                   mode_bit_hi,
  output logic                   mode_bit_lo,
  output logic                   powered_down
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CTRL = 4'h2,
    S_EXT  = 4'h4,
    S_INT  = 4'h8
  } state_t;

  localparam logic [4:0] CTRL_LAST  = 5'(CTRL_BITS - 1);
  localparam logic [4:0] K_RISE     = 5'(EXT_STRB_RISE);
  localparam logic [4:0] K_FALL     = 5'(EXT_STRB_FALL);
  localparam logic [4:0] K_MSB      = 5'(EXT_MSB_FALL);
  localparam logic [4:0] K_DONE     = 5'(EXT_DONE_FALL);
  localparam logic [3:0] TICK_LAST  = 4'(INT_STEP_CYC - 1);
  localparam logic [3:0] SHIFT_BITS = 4'(DATA_W);

  // ==========================================================
  // Pin synchronisers and serial clock edges
  pins_t pins_raw, s1_ff, s2_ff;
  logic  sclk_prev_ff;
  logic  rise_evt, fall_evt, cs_lo, shut;

  assign pins_raw = '{cs_n: cs_n, sclk: sclk, din: din, hard_powerdown_n: hard_powerdown_n};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff        <= PINS_RST;
      s2_ff        <= PINS_RST;
      sclk_prev_ff <= 1'b0;
    end else begin
      s1_ff        <= pins_raw;
      s2_ff        <= s1_ff;
      sclk_prev_ff <= s2_ff.sclk;
    end
  end

  // Edges are found by oversampling, so the serial clock must stay slow [RQ8]
  assign rise_evt = s2_ff.sclk && !sclk_prev_ff;
  assign fall_evt = !s2_ff.sclk && sclk_prev_ff;
  assign cs_lo    = !s2_ff.cs_n;
  assign shut     = !s2_ff.hard_powerdown_n;

  // ==========================================================
  // Conversion engine and result buffer
  logic              sar_start, sar_abort, sar_step;
  logic              sar_decision, sar_busy, sar_done;
  logic [DATA_W-1:0] sar_result, fifo_out_data;
  logic              fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;

  sar_core u_sar (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (sar_start),
    .abort       (sar_abort),
    .step        (sar_step),
    .sample_code (sample_code),
    .decision    (sar_decision),
    .busy        (sar_busy),
    .done        (sar_done),
    .result      (sar_result)
  );

  // An unread backlog stalls the internal-clock conversion before its strobe rises
  result_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (sar_result),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // Control sequencer
  state_t            state_ff, nxt_state;
  logic [4:0]        k_ff, nxt_k, kn;
  logic [7:0]        rx_ff, nxt_rx, rx_next;
  ctrl_byte_t        ctrl_ff, nxt_ctrl;
  logic [DATA_W-1:0] sh_ff, nxt_sh;
  logic [3:0]        shn_ff, nxt_shn, tick_ff, nxt_tick;
  logic              dout_ff, nxt_dout, dout_oe_ff, nxt_dout_oe;
  logic              strb_ff, nxt_strb, strb_oe_ff, nxt_strb_oe, pd_ff, nxt_pd;
  mode_t             mode_now;

  assign kn       = k_ff + 5'h01;
  assign rx_next  = {rx_ff[6:0], s2_ff.din};
  assign mode_now = byte_mode(ctrl_ff);

  always_comb begin
    nxt_state      = state_ff;
    nxt_k          = k_ff;
    nxt_rx         = rx_ff;
    nxt_ctrl       = ctrl_ff;
    nxt_sh         = sh_ff;
    nxt_shn        = shn_ff;
    nxt_tick       = tick_ff;
    nxt_dout       = dout_ff;
    nxt_strb       = strb_ff;
    nxt_pd         = pd_ff;
    nxt_dout_oe    = cs_lo && !shut; // [RQ2]
    nxt_strb_oe    = !shut && ((mode_now == MODE_INT_CLK) || cs_lo); // [RQ6]
    sar_start      = 1'b0;
    sar_abort      = 1'b0;
    sar_step       = 1'b0;
    fifo_in_valid  = 1'b0;
    fifo_out_ready = (shn_ff == 4'h0);
    if (fifo_out_valid && (shn_ff == 4'h0)) begin
      nxt_sh  = fifo_out_data;
      nxt_shn = SHIFT_BITS;
    end
    // Buffered result leaves MSB first, one bit per fall [RQ1] [RQ9]
    if (fall_evt && cs_lo && (state_ff != S_EXT)) begin
      if (shn_ff != 4'h0) begin
        nxt_dout = sh_ff[DATA_W-1];
        nxt_sh   = {sh_ff[DATA_W-2:0], 1'b0};
        nxt_shn  = shn_ff - 4'h1;
      end else begin
        nxt_dout = 1'b0;
      end
    end
    unique case (state_ff)
      S_IDLE: begin
        if (rise_evt && cs_lo && s2_ff.din) begin // [RQ11] [RQ3]
          nxt_state = S_CTRL;
          nxt_k     = 5'h01;
          nxt_rx    = 8'h01;
          nxt_pd    = 1'b0;
        end
      end
      S_CTRL: begin
        if (rise_evt) begin // [RQ3]
          nxt_rx = rx_next;
          nxt_k  = kn;
          if (k_ff == CTRL_LAST) begin // [RQ11]
            nxt_ctrl = rx_next;
            nxt_k    = 5'h00;
            nxt_strb = 1'b0;
            case (byte_mode(rx_next)) // [RQ12]
              MODE_EXT_CLK: begin
                nxt_state = S_EXT;
                sar_start = 1'b1;
              end
              MODE_INT_CLK: begin
                nxt_state = S_INT; // strobe already driven low above [RQ4]
                sar_start = 1'b1;
                nxt_tick  = 4'h0;
              end
              default: begin
                nxt_state = S_IDLE;
                nxt_pd    = 1'b1;
              end
            endcase
          end
        end
      end
      S_EXT: begin
        if (fall_evt) begin // [RQ7]
          nxt_k = kn;
          if (kn == K_RISE) begin
            nxt_strb = 1'b1; // [RQ5]
          end
          if (kn == K_FALL) begin
            nxt_strb = 1'b0; // [RQ5]
          end
          if (kn >= K_MSB) begin
            sar_step = 1'b1; // [RQ7]
            if (kn < K_DONE) begin
              nxt_dout = sar_decision; // [RQ1]
            end
          end
          if (kn == K_DONE) begin // [RQ14]
            nxt_state = S_IDLE;
            nxt_dout  = 1'b0;
          end
        end
      end
      S_INT: begin
        if (sar_busy) begin
          if (tick_ff == TICK_LAST) begin
            nxt_tick = 4'h0;
            sar_step = 1'b1;
          end else begin
            nxt_tick = tick_ff + 4'h1;
          end
        end
        if (sar_done) begin
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            nxt_strb  = 1'b1; // [RQ4]
            nxt_state = S_IDLE;
          end
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // Shutdown overrides the sequencer and converter but not the result shift-out; deselect ends all but internal conversions
    if (shut) begin // [RQ10]
      nxt_state     = S_IDLE;
      nxt_k         = 5'h00;
      nxt_ctrl      = ctrl_ff;
      nxt_strb      = 1'b0;
      nxt_pd        = 1'b1;
      sar_abort     = 1'b1;
      sar_start     = 1'b0;
      sar_step      = 1'b0;
      fifo_in_valid = 1'b0;
    end else if (!cs_lo && (state_ff != S_INT)) begin
      nxt_state = S_IDLE;
      nxt_k     = 5'h00;
      nxt_ctrl  = ctrl_ff;
      sar_start = 1'b0;
      if (state_ff == S_EXT) begin
        sar_abort = 1'b1;
        nxt_strb  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff   <= S_IDLE;
      k_ff       <= 5'h00;
      rx_ff      <= 8'h00;
      ctrl_ff    <= CTRL_RST;
      sh_ff      <= '0;
      shn_ff     <= 4'h0;
      tick_ff    <= 4'h0;
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
      strb_ff    <= 1'b0;
      strb_oe_ff <= 1'b0;
      pd_ff      <= PD_RST;
    end else begin
      state_ff   <= nxt_state;
      k_ff       <= nxt_k;
      rx_ff      <= nxt_rx;
      ctrl_ff    <= nxt_ctrl;
      sh_ff      <= nxt_sh;
      shn_ff     <= nxt_shn;
      tick_ff    <= nxt_tick;
      dout_ff    <= nxt_dout;
      dout_oe_ff <= nxt_dout_oe;
      strb_ff    <= nxt_strb;
      strb_oe_ff <= nxt_strb_oe;
      pd_ff      <= nxt_pd;
    end
  end

  assign dout                 = dout_ff;
  assign dout_oe              = dout_oe_ff;
  assign conversion_strobe    = strb_ff;
  assign conversion_strobe_oe = strb_oe_ff;
  assign channel_select       = ctrl_ff.channel_select;
  assign input_config_select  = ctrl_ff.input_config_select;
  assign polarity_select      = ctrl_ff.polarity_select;
  assign mode_bit_hi          = ctrl_ff.mode_bit_hi;
  assign mode_bit_lo          = ctrl_ff.mode_bit_lo;
  assign powered_down         = pd_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dout_on_fall;
    $changed(dout_ff) |-> $past(fall_evt);
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall) // [RQ1]
    else $error("result output moved without a serial fall");

  property p_dout_release;
    !cs_lo |=> !dout_oe_ff;
  endproperty
  a_dout_release: assert property (p_dout_release) // [RQ2]
    else $error("result output driven while deselected");

  property p_ctrl_on_rise;
    $changed(ctrl_ff) |-> $past(rise_evt && cs_lo);
  endproperty
  a_ctrl_on_rise: assert property (p_ctrl_on_rise) // [RQ3]
    else $error("control byte taken without a selected rising edge");

  property p_int_strobe_low;
    (state_ff == S_INT) |-> !strb_ff;
  endproperty
  a_int_strobe_low: assert property (p_int_strobe_low) // [RQ4]
    else $error("strobe high during internal conversion");

  property p_ext_strobe_window;
    (state_ff == S_EXT) |-> (strb_ff == ((k_ff == 5'h01) || (k_ff == 5'h02)));
  endproperty
  a_ext_strobe_window: assert property (p_ext_strobe_window) // [RQ5]
    else $error("external strobe outside its two-period window");

  property p_ext_strobe_release;
    (mode_now == MODE_EXT_CLK) && !cs_lo |=> !strb_oe_ff;
  endproperty
  a_ext_strobe_release: assert property (p_ext_strobe_release) // [RQ6]
    else $error("external strobe driven while deselected");

  property p_shutdown;
    shut |=> (state_ff == S_IDLE) && pd_ff && !sar_busy;
  endproperty
  a_shutdown: assert property (p_shutdown) // [RQ10]
    else $error("shutdown did not stop the port");

  property p_start_bit;
    (state_ff == S_IDLE) && rise_evt && cs_lo && !shut && s2_ff.din |=> (state_ff == S_CTRL);
  endproperty
  a_start_bit: assert property (p_start_bit) // [RQ11]
    else $error("start bit not recognised");

  property p_int_mode_entry;
    $changed(ctrl_ff) && (mode_now == MODE_INT_CLK) |-> (state_ff == S_INT) && sar_busy;
  endproperty
  a_int_mode_entry: assert property (p_int_mode_entry) // [RQ12]
    else $error("internal clock byte did not start a conversion");

  property p_ext_done;
    (state_ff == S_EXT) && fall_evt && cs_lo && !shut && (k_ff == 5'h11)
      |=> sar_done && (state_ff == S_IDLE);
  endproperty
  a_ext_done: assert property (p_ext_done) // [RQ14]
    else $error("external conversion not complete on its last fall");

  c_ext_conv: cover property ((state_ff == S_EXT) ##1 (state_ff == S_IDLE) && sar_done);
  c_int_push: cover property (fifo_in_valid && fifo_in_ready);
  c_fifo_full: cover property (!fifo_in_ready);
  c_shutdown: cover property ($rose(shut) && (state_ff != S_IDLE));

endmodule : adc_serial_conversion_port

// File: rtl/conv_pkg.sv
/*
  Shared types and constants of the serial conversion port: pin and
  control byte carriers, clock modes and the step counts of a conversion.
  Assumes a 20 MHz system clock and slow serial pins sampled by it.
*/
package conv_pkg;

  // ==========================================================
  // Widths and depths
  localparam int DATA_W     = 14;
  localparam int FIFO_DEPTH = 8;
  localparam int CTRL_BITS  = 8;

  // ==========================================================
  // Timing
  localparam int CLK_NS        = 50;
  localparam int INT_STEP_NS   = 450;
  localparam int INT_STEP_CYC  = (INT_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAR_STEPS     = 15;
  localparam int EXT_STRB_RISE = 1;
  localparam int EXT_STRB_FALL = 3;
  localparam int EXT_MSB_FALL  = 4;
  localparam int EXT_DONE_FALL = 18;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic hard_powerdown_n;
  } pins_t;

  typedef struct packed {
    logic       start;
    logic [2:0] channel_select;
    logic       input_config_select;
    logic       polarity_select;
    logic       mode_bit_hi;
    logic       mode_bit_lo;
  } ctrl_byte_t;

  typedef enum logic [1:0] {
    MODE_FULL_PD = 2'h0,
    MODE_FAST_PD = 2'h1,
    MODE_INT_CLK = 2'h2,
    MODE_EXT_CLK = 2'h3
  } mode_t;

  // ==========================================================
  // Reset values
  localparam pins_t      PINS_RST = 4'h9;
  localparam ctrl_byte_t CTRL_RST = 8'h00;
  localparam logic       PD_RST   = 1'b1;
  localparam logic [DATA_W-1:0] SAR_MSB = 14'h2000;

  function automatic mode_t byte_mode(input ctrl_byte_t b);
    return mode_t'({b.mode_bit_hi, b.mode_bit_lo});
  endfunction : byte_mode

endpackage : conv_pkg

// File: rtl/result_fifo.sv
/*
  Small synchronous FIFO for conversion results, valid/ready on both sides.
  Assumes one clock; a push into a full FIFO is simply not accepted.
*/
`timescale 1ns/1ps
module result_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          push, pop;

  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    if (push) begin
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
    end
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; only words below the count are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

endmodule : result_fifo

// File: rtl/sar_core.sv
/*
  Successive-approximation sequencer: holds the sample at start, decides
  one bit on each step but the last, from the top down, and finishes on the last step.
  Assumes step pulses come from the caller's conversion clock.
*/
`timescale 1ns/1ps
module sar_core
  import conv_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic              step,
  input  wire logic [DATA_W-1:0] sample_code,
  // Results
  output logic                   decision,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      result
);
  localparam logic [3:0] SAR_LAST = 4'(SAR_STEPS - 1);

  logic [DATA_W-1:0] held_ff, res_ff, mask_ff, nxt_held, nxt_res, nxt_mask;
  logic [3:0]        cnt_ff, nxt_cnt;
  logic              busy_ff, done_ff, nxt_busy, nxt_done;

  assign decision = (held_ff >= (res_ff | mask_ff));
  assign busy     = busy_ff;
  assign done     = done_ff;
  assign result   = res_ff;

  always_comb begin
    nxt_held = held_ff;
    nxt_res  = res_ff;
    nxt_mask = mask_ff;
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    if (abort) begin
      nxt_busy = 1'b0;
      nxt_done = 1'b0;
    end else if (start) begin
      nxt_held = sample_code;
      nxt_res  = '0;
      nxt_mask = SAR_MSB;
      nxt_cnt  = '0;
      nxt_busy = 1'b1;
      nxt_done = 1'b0;
    end else if (step && busy_ff) begin
      // Last step settles the result after the final bit decision [RQ13]
      if (cnt_ff == SAR_LAST) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_res  = decision ? (res_ff | mask_ff) : res_ff;
        nxt_mask = mask_ff >> 1;
        nxt_cnt  = cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_ff <= '0;
      res_ff  <= '0;
      mask_ff <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      held_ff <= nxt_held;
      res_ff  <= nxt_res;
      mask_ff <= nxt_mask;
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // ==========================================================
  // Checks
  property p_fifteen_steps;
    @(posedge clk) disable iff (!rst_n)
      $rose(done_ff) |-> ($past(cnt_ff) == 4'he) && $past(step);
  endproperty
  a_fifteen_steps: assert property (p_fifteen_steps) // [RQ13]
    else $error("conversion finished without fifteen steps");

endmodule : sar_core
